// >>> hdl/reset_pin_pkg.sv
// Constants and carrier types for the external reset pin logic
package reset_pin_pkg;
    // Cycles that the soft reset pin is driven low per drive interval
    localparam logic [2:0] SOFT_DRIVE_CYCLES = 3'h6;
    localparam logic [2:0] DRIVE_CNT_ZERO = 3'h0;
    localparam logic [2:0] DRIVE_CNT_ONE = 3'h1;
    // Cycles that the pin is sensed as input after a drive interval;
    // the pin's own drive takes four edges to leave the synchroniser
    localparam logic [2:0] SENSE_SETTLE_CYCLES = 3'h5;
    localparam logic [2:0] SETTLE_CNT_ZERO = 3'h0;
    localparam logic [2:0] SETTLE_CNT_ONE = 3'h1;

    // Soft reset pin sequencer states
    typedef enum logic [1:0] {
        SOFT_IDLE = 2'b00,
        SOFT_DRIVE = 2'b01,
        SOFT_SENSE = 2'b10
    } soft_state_type;

    // Reset outputs to the rest of the device
    typedef struct packed {
        logic por_reset;
        logic core_reset;
        logic run_enable;
    } reset_out_type;

    // Two-signal view of the soft reset pin
    typedef struct packed {
        logic drive_out;
        logic drive_oe;
    } pin_drive_type;
endpackage

// >>> hdl/pin_sync3.sv
// Three-stage input synchroniser with agreement check
`timescale 1ns/1ps
`default_nettype none
module pin_sync3 (
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic pin_in,
    output logic level_out
);
    logic meta_q;
    logic s2_q;
    logic s3_q;
    logic level_q;

    // Shift chain; a change counts once stage two and three agree
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            meta_q <= 1'b1;
            s2_q <= 1'b1;
            s3_q <= 1'b1;
            level_q <= 1'b1;
        end else begin
            meta_q <= pin_in;
            s2_q <= meta_q;
            s3_q <= s2_q;
            if (s2_q == s3_q) begin
                level_q <= s3_q;
            end
        end
    end

    assign level_out = level_q;
endmodule
`default_nettype wire

// >>> hdl/external_reset_pin_logic.sv
// External hardware and soft reset pin sequencer
`timescale 1ns/1ps
`default_nettype none
// Operation
// - Whole device held in reset while the hardware reset pin is low.
// - On hardware release, apply power-on reset except RTC, then start running.
// - Device stays in soft reset while the soft reset pin reads low.
// - On soft release, reset core, digital registers and peripherals.
// - Soft reset leaves POR-only registers, RTC and debug logic untouched.
// - Once soft pin is sensed low, drive it low for six clock cycles.
// - Then release to input, sense again, repeat until pin reads high.
module external_reset_pin_logic
    import reset_pin_pkg::*;
(
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic hardware_reset_in_n,
    input wire logic soft_reset_io_n_in,
    output logic soft_reset_io_n_out,
    output logic soft_reset_io_n_oe,
    output logic por_reset,
    output logic core_reset,
    output logic run_enable
);
    logic hw_n_sync;
    logic soft_n_sync;
    soft_state_type state_q;
    soft_state_type state_d;
    logic [2:0] drive_cnt_q;
    logic [2:0] drive_cnt_d;
    logic [2:0] settle_cnt_q;
    logic [2:0] settle_cnt_d;
    reset_out_type rout_q;
    reset_out_type rout_d;
    pin_drive_type pin_q;
    pin_drive_type pin_d;

    // Pin synchronisers
    pin_sync3 hw_sync (
        .sys_clk(sys_clk),
        .rst(rst),
        .pin_in(hardware_reset_in_n),
        .level_out(hw_n_sync)
    );
    pin_sync3 soft_sync (
        .sys_clk(sys_clk),
        .rst(rst),
        .pin_in(soft_reset_io_n_in),
        .level_out(soft_n_sync)
    );

    // Named decode terms
    wire hw_active = ~hw_n_sync;
    wire soft_sensed_low = ~soft_n_sync;
    wire drive_done = (drive_cnt_q == DRIVE_CNT_ONE);
    // Sense decision falls on the last settle cycle, after the synchroniser
    // has flushed the low level that the pin's own drive left in it
    wire settle_done = (settle_cnt_q == SETTLE_CNT_ONE);
    wire in_soft = (state_q != SOFT_IDLE);

    // Soft pin sequencer: drive low six cycles, then sense again
    always_comb begin
        state_d = state_q;
        drive_cnt_d = drive_cnt_q;
        settle_cnt_d = settle_cnt_q;
        case (state_q)
            SOFT_IDLE: begin
                if (soft_sensed_low) begin
                    state_d = SOFT_DRIVE;
                    drive_cnt_d = SOFT_DRIVE_CYCLES;
                end
            end
            SOFT_DRIVE: begin
                drive_cnt_d = drive_cnt_q - DRIVE_CNT_ONE;
                if (drive_done) begin
                    state_d = SOFT_SENSE;
                    settle_cnt_d = SENSE_SETTLE_CYCLES;
                end
            end
            SOFT_SENSE: begin
                // Pin is released here; wait out the settle window so the
                // synchroniser shows the pin's own level, not our drive
                settle_cnt_d = settle_cnt_q - SETTLE_CNT_ONE;
                if (settle_done) begin
                    if (soft_sensed_low) begin
                        state_d = SOFT_DRIVE;
                        drive_cnt_d = SOFT_DRIVE_CYCLES;
                    end else begin
                        state_d = SOFT_IDLE;
                    end
                end
            end
            default: begin
                state_d = SOFT_IDLE;
                drive_cnt_d = DRIVE_CNT_ZERO;
                settle_cnt_d = SETTLE_CNT_ZERO;
            end
        endcase
        // Hardware reset overrides the soft sequence
        if (hw_active) begin
            state_d = SOFT_IDLE;
            drive_cnt_d = DRIVE_CNT_ZERO;
            settle_cnt_d = SETTLE_CNT_ZERO;
        end
    end

    // Reset outputs and pin drive
    always_comb begin
        // POR domain follows hardware pin only, never the soft pin
        rout_d.por_reset = hw_active;
        // Core domain held by either source; release runs core reset
        rout_d.core_reset = hw_active | in_soft | soft_sensed_low;
        rout_d.run_enable = ~rout_d.core_reset;
        // Pin drive follows the next state so oe lines up with state_q
        pin_d.drive_oe = (state_d == SOFT_DRIVE);
        pin_d.drive_out = 1'b0;
    end

    // State registers
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            state_q <= SOFT_IDLE;
            drive_cnt_q <= DRIVE_CNT_ZERO;
            settle_cnt_q <= SETTLE_CNT_ZERO;
        end else begin
            state_q <= state_d;
            drive_cnt_q <= drive_cnt_d;
            settle_cnt_q <= settle_cnt_d;
        end
    end

    // Output registers; everything held in reset while rst is high
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            rout_q <= '{por_reset: 1'b1, core_reset: 1'b1, run_enable: 1'b0};
            pin_q <= '{drive_out: 1'b0, drive_oe: 1'b0};
        end else begin
            rout_q <= rout_d;
            pin_q <= pin_d;
        end
    end

    assign por_reset = rout_q.por_reset;
    assign core_reset = rout_q.core_reset;
    assign run_enable = rout_q.run_enable;
    assign soft_reset_io_n_out = pin_q.drive_out;
    assign soft_reset_io_n_oe = pin_q.drive_oe;

    // Checks
    hw_hold_a: assert property (@(posedge sys_clk) disable iff (rst)
        hw_active |=> por_reset && core_reset && !run_enable)
        else $error("hardware reset not held");
    hw_release_a: assert property (@(posedge sys_clk) disable iff (rst)
        $fell(hw_active) |=> !por_reset)
        else $error("power-on reset not released");
    soft_hold_a: assert property (@(posedge sys_clk) disable iff (rst)
        soft_sensed_low |=> core_reset && !run_enable)
        else $error("soft reset not held");
    soft_no_por_a: assert property (@(posedge sys_clk) disable iff (rst)
        !hw_active && soft_sensed_low |=> !por_reset)
        else $error("soft reset touched power-on domain");
    soft_release_a: assert property (@(posedge sys_clk) disable iff (rst)
        !hw_active && !soft_sensed_low && !in_soft |=> !core_reset)
        else $error("core reset not released");
    drive_six_a: assert property (@(posedge sys_clk)
        disable iff (rst || hw_active)
        $rose(soft_reset_io_n_oe) && !hw_active |->
            soft_reset_io_n_oe[*6] ##1 !soft_reset_io_n_oe)
        else $error("drive interval not six cycles");
    drive_low_a: assert property (@(posedge sys_clk) disable iff (rst)
        soft_reset_io_n_oe |-> !soft_reset_io_n_out)
        else $error("soft pin driven high");
    redrive_a: assert property (@(posedge sys_clk) disable iff (rst)
        state_q == SOFT_SENSE && settle_done && soft_sensed_low && !hw_active
        |=> state_q == SOFT_DRIVE)
        else $error("drive not repeated");
    sense_gap_a: assert property (@(posedge sys_clk) disable iff (rst)
        $fell(soft_reset_io_n_oe) |-> !soft_reset_io_n_oe[*5])
        else $error("pin not released for sensing");
    sync_delay_a: assert property (@(posedge sys_clk) disable iff (rst)
        $fell(hw_n_sync) |-> $past(hardware_reset_in_n, 3) == 1'b0)
        else $error("synchroniser bypassed");
    soft_sync_a: assert property (@(posedge sys_clk) disable iff (rst)
        $fell(soft_n_sync) |-> $past(soft_reset_io_n_in, 3) == 1'b0)
        else $error("soft synchroniser bypassed");

    // Sequencing checks around hardware override and soft entry and exit
    hw_abort_a: assert property (@(posedge sys_clk) disable iff (rst)
        hw_active |=> state_q == SOFT_IDLE && !soft_reset_io_n_oe)
        else $error("soft sequence ran under hardware reset");
    por_hw_only_a: assert property (@(posedge sys_clk) disable iff (rst)
        !hw_active |=> !por_reset)
        else $error("power-on reset without hardware pin");
    core_in_seq_a: assert property (@(posedge sys_clk) disable iff (rst)
        in_soft |=> core_reset && !run_enable)
        else $error("core ran during soft sequence");
    soft_entry_a: assert property (@(posedge sys_clk) disable iff (rst)
        state_q == SOFT_IDLE && soft_sensed_low && !hw_active
        |=> soft_reset_io_n_oe)
        else $error("soft pin not driven after sensing low");
    idle_release_a: assert property (@(posedge sys_clk) disable iff (rst)
        state_q == SOFT_SENSE && settle_done && !soft_sensed_low && !hw_active
        |=> state_q == SOFT_IDLE)
        else $error("soft sequence did not end on release");

    // Coverage of the main scenarios
    wire redrive_cond = (state_q == SOFT_SENSE) && settle_done
        && soft_sensed_low;
    wire release_cond = (state_q == SOFT_SENSE) && settle_done
        && !soft_sensed_low;
    soft_cycle_c: cover property (@(posedge sys_clk) disable iff (rst)
        $rose(soft_reset_io_n_oe));
    soft_repeat_c: cover property (@(posedge sys_clk) disable iff (rst)
        redrive_cond);
    hw_release_c: cover property (@(posedge sys_clk) disable iff (rst)
        $fell(por_reset));
    sense_release_c: cover property (@(posedge sys_clk) disable iff (rst)
        release_cond);
    soft_release_c: cover property (@(posedge sys_clk) disable iff (rst)
        $fell(core_reset) && !por_reset);
endmodule
`default_nettype wire

// >>> tb/reset_source_model.sv
// External reset source model for the hardware and soft reset pins
`timescale 1ns/1ps
`default_nettype none
module reset_source_model (
    input wire logic sys_clk,
    output logic hardware_reset_in_n,
    output logic soft_pull_low
);
    // Both pins start released to their pull-ups
    initial begin
        hardware_reset_in_n = 1'b1;
        soft_pull_low = 1'b0;
    end
    // Hold the hardware reset pin low for n cycles
    task automatic hold_hw(input int n);
        @(negedge sys_clk);
        hardware_reset_in_n = 1'b0;
        repeat (n) @(negedge sys_clk);
        hardware_reset_in_n = 1'b1;
    endtask
    // Pull the open-drain soft pin low for n cycles, then let go
    task automatic hold_soft(input int n);
        @(negedge sys_clk);
        soft_pull_low = 1'b1;
        repeat (n) @(negedge sys_clk);
        soft_pull_low = 1'b0;
    endtask
endmodule
`default_nettype wire

// >>> tb/test_external_reset_pin_logic.sv
// Self-checking testbench for the external reset pin logic
`timescale 1ns/1ps
`default_nettype none
module test_external_reset_pin_logic;
    logic sys_clk = 1'b0;
    logic rst = 1'b1;
    logic hw_n, src_low, pin_out, pin_oe, por_reset, core_reset, run_enable;
    logic soft_wire;
    int num_errors = 0;
    int n_checks = 0;
    int drive_len = 0;
    int drive_count = 0;
    int start;
    always #20 sys_clk = ~sys_clk;
    // Pull-up on the soft wire; either party may pull it low
    assign soft_wire = ((pin_oe === 1'b1 && pin_out === 1'b0) || src_low) ?
        1'b0 : 1'b1;
    reset_source_model partner (.sys_clk(sys_clk),
        .hardware_reset_in_n(hw_n), .soft_pull_low(src_low));
    external_reset_pin_logic DUT (.sys_clk(sys_clk), .rst(rst),
        .hardware_reset_in_n(hw_n), .soft_reset_io_n_in(soft_wire),
        .soft_reset_io_n_out(pin_out), .soft_reset_io_n_oe(pin_oe),
        .por_reset(por_reset), .core_reset(core_reset),
        .run_enable(run_enable));
    task automatic chk(input string what, input logic exp, input logic got);
        n_checks++;
        if (got !== exp) begin
            num_errors++;
            $display("wrong value %s expected %b seen %b", what, exp, got);
        end
    endtask
    task automatic summarize();
        $display("checks %0d mismatches %0d", n_checks, num_errors);
        if (num_errors == 0 && n_checks > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask
    // Measures each low-driving interval at the settled falling edge
    always @(negedge sys_clk) begin
        if (pin_oe === 1'b1) begin
            drive_len <= drive_len + 1;
            chk("drive level", 1'b0, pin_out);
            chk("por during soft", 1'b0, por_reset);
        end else if (drive_len != 0) begin
            chk("drive length six", 1'b1, drive_len == 6);
            drive_count <= drive_count + 1;
            drive_len <= 0;
        end
    end
    // Waits a bounded time for the core to leave reset
    task automatic wait_core_free();
        int i;
        for (i = 0; i < 80 && !(core_reset === 1'b0 && pin_oe === 1'b0); i++)
            @(negedge sys_clk);
        if (i == 80) begin
            chk("core release in time", 1'b1, 1'b0);
            summarize();
        end
    endtask
    task automatic test_hw_reset();
        start = drive_count;
        fork
            partner.hold_hw(24);
        join_none
        repeat (4) @(negedge sys_clk);
        partner.hold_soft(3);
        repeat (6) @(negedge sys_clk);
        chk("por held", 1'b1, por_reset);
        chk("core held", 1'b1, core_reset);
        chk("run stopped", 1'b0, run_enable);
        chk("no soft drive", 1'b0, pin_oe);
        repeat (20) @(negedge sys_clk);
        chk("por released", 1'b0, por_reset);
        chk("running", 1'b1, run_enable);
        chk("no drive seen", 1'b1, drive_count == start);
        $display("test_hw_reset done");
    endtask
    task automatic test_soft_short();
        start = drive_count;
        partner.hold_soft(2);
        repeat (8) @(negedge sys_clk);
        chk("core held", 1'b1, core_reset);
        chk("run stopped", 1'b0, run_enable);
        chk("por kept", 1'b0, por_reset);
        wait_core_free();
        chk("drove once", 1'b1, drive_count > start);
        chk("running", 1'b1, run_enable);
        chk("pin idle", 1'b0, pin_oe);
        $display("test_soft_short done");
    endtask
    task automatic test_soft_long();
        start = drive_count;
        fork
            partner.hold_soft(30);
        join_none
        repeat (24) @(negedge sys_clk);
        chk("core held long", 1'b1, core_reset);
        repeat (8) @(negedge sys_clk);
        wait_core_free();
        chk("redrive", 1'b1, drive_count - start >= 2);
        chk("running", 1'b1, run_enable);
        $display("test_soft_long done");
    endtask
    initial begin
        repeat (8) @(negedge sys_clk);
        rst = 1'b0;
        repeat (8) @(negedge sys_clk);
        chk("por after start", 1'b0, por_reset);
        chk("run after start", 1'b1, run_enable);
        test_hw_reset();
        test_soft_short();
        test_soft_long();
        summarize();
    end
endmodule
`default_nettype wire
